// ==== logic/sar_adc_regs.svh ====
// Constants for the converter control: widths, field positions and timing.
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH
`define RES_W 12
`define RES_MSB 4'hb
`define RES_MSB_MASK 12'h800
`define CLK_NS 40
`define WAKE_NS 350
`define STEP_NS 120
`define WAKE_CYC (`WAKE_NS / `CLK_NS)
`define STEP_CYC (`STEP_NS / `CLK_NS)
`define CONV_CYC (`STEP_CYC * `RES_W)
`define PIN_N 6
`define PIN_PD 0
`define PIN_CS 1
`define PIN_CONV 2
`define PIN_RD 3
`define PIN_CMP 4
`define PIN_BIP 5
`endif

// ==== logic/sar_adc_pkg.sv ====
// Types shared by the converter control.
`include "sar_adc_regs.svh"
package sar_adc_pkg;
    typedef logic [`RES_W-1:0] sar_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_STORE = 2'h3,
        ST_SLEEP = 2'h2
    } state_e;
endpackage : sar_adc_pkg

// ==== logic/sar_adc_conversion_control.sv ====
// Control logic of a 12-bit successive-approximation converter.
// Summary of operation
// - Power-down low holds the converter in shutdown.
// - Falling start edge begins a conversion.
// - Start ignored unless chip select low.
// - Data driven only with read and select low.
// - Busy low during whole conversion.
// - Twelve-bit result, top line is MSB.
// - Approximation register cleared at conversion start.
// - Start edges during conversion are ignored.
// - Bits resolved one by one, MSB first.
// - Finished register copied to output latch.
// - No conversion starts while shut down.
// - Active again within wake time after release.
// - Straight binary unipolar, two's complement bipolar.
`timescale 1ns/1ps
`include "sar_adc_regs.svh"
module sar_adc_conversion_control (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic power_down_n_in,
    input wire logic chip_select_n_in,
    input wire logic convert_start_n_in,
    input wire logic read_n_in,
    input wire logic comparator_in,
    input wire logic bipolar_in,
    output sar_adc_pkg::sar_t dac_code_out,
    output logic busy_n_out,
    output logic powered_out,
    output sar_adc_pkg::sar_t result_bits_out,
    output logic result_bits_oe_out,
    output logic result_valid_out
);
    import sar_adc_pkg::*;

    localparam int NPIN = `PIN_N;

    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic conv_prev_reg;
    logic rd_act_reg;
    state_e state_reg;
    sar_t sar_reg;
    logic [3:0] bit_idx_reg;
    logic [1:0] step_reg;
    logic [3:0] wake_reg;
    sar_t buf_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic start_fall;
    logic start_take;
    logic step_end;
    logic rd_act;
    logic push;
    logic pop;
    logic buf_ready;
    sar_t store_word;

    // Returns a one-hot mask for the given bit position.
    function automatic sar_t bit_mask(input logic [3:0] idx);
        bit_mask = sar_t'(1) << idx;
    endfunction : bit_mask

    assign pins = {bipolar_in, comparator_in, read_n_in, convert_start_n_in,
                   chip_select_n_in, power_down_n_in};

    // Every pin passes two flip-flops before any logic reads it.
    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_sync
            always_ff @(posedge clk_sys_in) begin
                if (srst_in) begin
                    sync1_reg[i] <= 1'b1;
                    sync2_reg[i] <= 1'b1;
                end else if (ce_in) begin
                    sync1_reg[i] <= pins[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    // Edge and strobe decoding on the synchronised pins.
    assign start_fall = conv_prev_reg && !sync2_reg[`PIN_CONV]
                        && !sync2_reg[`PIN_CS];
    assign rd_act = !sync2_reg[`PIN_CS] && !sync2_reg[`PIN_RD];
    // A start counts only when the sequencer itself moves to convert.
    assign start_take = (state_reg == ST_IDLE) && start_fall && sync2_reg[`PIN_PD]
                        && (wake_reg == 4'(`WAKE_CYC));
    assign step_end = (step_reg == 2'(`STEP_CYC - 1));

    // Previous start level and read activity for edge detection.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            conv_prev_reg <= 1'b1;
            rd_act_reg <= 1'b0;
        end else if (ce_in) begin
            conv_prev_reg <= sync2_reg[`PIN_CONV];
            rd_act_reg <= rd_act;
        end
    end

    // Main sequencer: shutdown, idle, bit decisions, result store.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE;
            wake_reg <= 4'h0;
        end else if (ce_in) begin
            case (state_reg)
                ST_IDLE: begin
                    if (!sync2_reg[`PIN_PD]) begin
                        state_reg <= ST_SLEEP;
                    end else if (start_fall && wake_reg == 4'(`WAKE_CYC)) begin
                        state_reg <= ST_CONV;
                    end else if (wake_reg != 4'(`WAKE_CYC)) begin
                        wake_reg <= wake_reg + 4'h1;
                    end
                end
                ST_CONV: begin
                    // Start edges are not decoded here, so only power-down can cut a conversion short.
                    if (!sync2_reg[`PIN_PD]) begin
                        state_reg <= ST_SLEEP;
                    end else if (step_end && bit_idx_reg == 4'h0) begin
                        state_reg <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (!sync2_reg[`PIN_PD]) begin
                        state_reg <= ST_SLEEP;
                    end else if (buf_ready) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_SLEEP: begin
                    wake_reg <= 4'h0;
                    if (sync2_reg[`PIN_PD]) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Approximation register, bit pointer and self-timed step counter.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            sar_reg <= '0;
            bit_idx_reg <= `RES_MSB;
            step_reg <= 2'h0;
        end else if (ce_in) begin
            if (start_take) begin
                sar_reg <= `RES_MSB_MASK;
                bit_idx_reg <= `RES_MSB;
                step_reg <= 2'h0;
            end else if (state_reg == ST_CONV) begin
                step_reg <= step_end ? 2'h0 : step_reg + 2'h1;
                if (step_end) begin
                    // Keep or drop the trial bit, then try the next one down.
                    sar_reg[bit_idx_reg] <= sync2_reg[`PIN_CMP];
                    if (bit_idx_reg != 4'h0) begin
                        sar_reg <= (sar_reg & ~bit_mask(bit_idx_reg))
                                   | (sync2_reg[`PIN_CMP] ? bit_mask(bit_idx_reg) : '0)
                                   | bit_mask(bit_idx_reg - 4'h1);
                        bit_idx_reg <= bit_idx_reg - 4'h1;
                    end
                end
            end
        end
    end

    // Result coding: MSB inverted turns offset binary into two's complement.
    assign store_word = sar_reg ^ (sync2_reg[`PIN_BIP] ? `RES_MSB_MASK : '0);

    // Two-entry result buffer; a full buffer holds the converter in store.
    assign buf_ready = (count_reg != 2'h2);
    assign push = (state_reg == ST_STORE) && buf_ready && sync2_reg[`PIN_PD];
    assign pop = rd_act_reg && !rd_act && (count_reg != 2'h0);

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else if (ce_in) begin
            if (push) begin
                buf_reg[wr_ptr_reg] <= store_word;
                wr_ptr_reg <= !wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= !rd_ptr_reg;
            end
            count_reg <= count_reg + 2'(push) - 2'(pop);
        end
    end

    // Output latch follows the buffer head while no read is in progress.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            result_bits_out <= '0;
        end else if (ce_in && !rd_act && count_reg != 2'h0) begin
            result_bits_out <= buf_reg[rd_ptr_reg];
        end
    end

    // Pin-side status and drive enables.
    assign dac_code_out = sar_reg;
    assign busy_n_out = !(state_reg == ST_CONV || state_reg == ST_STORE);
    assign powered_out = (state_reg != ST_SLEEP);
    assign result_bits_oe_out = rd_act;
    assign result_valid_out = (count_reg != 2'h0);

    // Checks on the sequencer and pins.
    logic [5:0] conv_cnt_reg;
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || state_reg != ST_CONV) begin
            conv_cnt_reg <= 6'h0;
        end else if (ce_in) begin
            conv_cnt_reg <= conv_cnt_reg + 6'h1;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    a_pd_enter: assert property (ce_in && !sync2_reg[`PIN_PD] |=> state_reg == ST_SLEEP)
        else $error("power-down did not reach shutdown");
    a_start_go: assert property (ce_in && state_reg == ST_IDLE && start_fall
        && sync2_reg[`PIN_PD] && wake_reg == 4'(`WAKE_CYC) |=> !busy_n_out)
        else $error("accepted start did not lower busy");
    a_cs_gate: assert property (ce_in && state_reg == ST_IDLE && sync2_reg[`PIN_CS]
        |=> busy_n_out)
        else $error("start taken without chip select");
    a_oe_gate: assert property ($past(ce_in) && $past(ce_in, 2) && result_bits_oe_out
        |-> $past(chip_select_n_in, 2) == 1'b0 && $past(read_n_in, 2) == 1'b0)
        else $error("data driven without read and select");
    a_sar_clear: assert property (ce_in && state_reg == ST_IDLE && start_fall
        && sync2_reg[`PIN_PD] && wake_reg == 4'(`WAKE_CYC) |=> sar_reg == `RES_MSB_MASK)
        else $error("approximation register not cleared");
    a_no_restart: assert property (ce_in && state_reg == ST_CONV && sync2_reg[`PIN_PD]
        && !(step_end && bit_idx_reg == 4'h0) |=> state_reg == ST_CONV)
        else $error("conversion interrupted");
    a_bit_order: assert property (ce_in && state_reg == ST_CONV && step_end
        && bit_idx_reg != 4'h0 |=> bit_idx_reg == $past(bit_idx_reg) - 4'h1)
        else $error("bit order broken");
    a_conv_len: assert property (ce_in && state_reg == ST_CONV && sync2_reg[`PIN_PD]
        && step_end && bit_idx_reg == 4'h0 |-> conv_cnt_reg == 6'(`CONV_CYC - 1))
        else $error("conversion length wrong");
    a_sleep_block: assert property (ce_in && state_reg == ST_SLEEP |=> busy_n_out)
        else $error("conversion started in shutdown");
    a_busy_span: assert property (ce_in && state_reg == ST_CONV && sync2_reg[`PIN_PD]
        |=> !busy_n_out)
        else $error("busy released early");
endmodule : sar_adc_conversion_control

// ==== dv/sar_adc_analog_model.sv ====
// Comparator model that weighs each trial code against a held analog level.
`timescale 1ns/1ps
module sar_adc_analog_model (
    input wire logic [11:0] level_in,
    input wire logic [11:0] dac_code_in,
    output logic comparator_out
);
    // The trial bit is kept while the trial code does not exceed the level.
    assign #1 comparator_out = (dac_code_in <= level_in);
endmodule : sar_adc_analog_model

// ==== dv/sar_adc_conversion_control_tb.sv ====
// Self-checking bench for the converter control.
`timescale 1ns/1ps
module sar_adc_conversion_control_tb;
    import sar_adc_pkg::*;
    logic clk_sys_in = 1'b0;
    logic ce = 1'b1;
    logic srst_in = 1'b1;
    logic pd_n = 1'b1, cs_n = 1'b1, cv_n = 1'b1, rd_n = 1'b1, bip = 1'b0;
    logic cmp, busy_n, pwr, oe, vld;
    logic [11:0] lvl = 12'h000;
    sar_t dac, res;
    int failures = 0;
    int n_checks = 0;
    int k;
    // The clock toggles every half period of 20 ns.
    always #20 clk_sys_in = ~clk_sys_in;
    sar_adc_conversion_control sar_adc_conversion_control_inst (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce),
        .power_down_n_in(pd_n), .chip_select_n_in(cs_n), .convert_start_n_in(cv_n),
        .read_n_in(rd_n), .comparator_in(cmp), .bipolar_in(bip), .dac_code_out(dac),
        .busy_n_out(busy_n), .powered_out(pwr), .result_bits_out(res),
        .result_bits_oe_out(oe), .result_valid_out(vld));
    sar_adc_analog_model sar_adc_analog_model_inst (
        .level_in(lvl), .dac_code_in(dac), .comparator_out(cmp));
    // Inputs always change 2 ns after a rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #2;
    endtask : tick
    task automatic chk_word(input sar_t got, input sar_t exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    // Bipolar coding flips the top bit of the straight binary code.
    function automatic sar_t coded(input logic [11:0] l, input logic b);
        return b ? (l ^ 12'h800) : l;
    endfunction : coded
    // One conversion; a second start falls mid-way when mid is set; len 0 skips the count.
    task automatic conv(input logic [11:0] l, input logic b, input logic mid, input int len);
        int n;
        n = 0;
        lvl = l;
        bip = b;
        cs_n = 1'b0;
        tick(1);
        cv_n = 1'b0;
        tick(2);
        cv_n = 1'b1;
        while (busy_n !== 1'b0 && n < 10) begin
            tick(1);
            n++;
        end
        chk_bit(busy_n, 1'b0);
        chk_word(dac, 12'h800);
        n = 0;
        while (busy_n === 1'b0 && n < 300) begin
            if (mid && n == 10) cv_n = 1'b0;
            tick(1);
            n++;
        end
        cv_n = 1'b1;
        if (len != 0) chk_word(12'(n), 12'(len));
        cs_n = 1'b1;
        tick(4);
    endtask : conv
    // One read of the oldest result.
    task automatic rd(input sar_t exp);
        int n;
        n = 0;
        cs_n = 1'b0;
        rd_n = 1'b0;
        while (oe !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk_bit(oe, 1'b1);
        chk_word(res, exp);
        rd_n = 1'b1;
        tick(1);
        cs_n = 1'b1;
        tick(4);
        chk_bit(oe, 1'b0);
    endtask : rd
    task automatic close_out();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // A hang is cut short long after the tests should have ended.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        close_out();
    end
    initial begin
        logic [11:0] l;
        logic b;
        void'($urandom(2662));
        tick(10);
        srst_in = 1'b0;
        chk_bit(busy_n, 1'b1);
        chk_bit(oe, 1'b0);
        tick(12);
        $display("test reset done");
        // Corner levels first, then random levels and codings.
        for (k = 0; k < 8; k++) begin
            l = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : (k == 2) ? 12'h7ff : 12'($urandom);
            b = 1'($urandom);
            conv(l, b, k[0], 37);
            rd(coded(l, b));
        end
        $display("test random done");
        // Start or read with select high is ignored.
        rd_n = 1'b0;
        cv_n = 1'b0;
        tick(2);
        cv_n = 1'b1;
        tick(6);
        chk_bit(oe, 1'b0);
        chk_bit(busy_n, 1'b1);
        rd_n = 1'b1;
        $display("test select done");
        // A start while shut down is ignored; after wake-up it works.
        pd_n = 1'b0;
        tick(4);
        chk_bit(pwr, 1'b0);
        cs_n = 1'b0;
        cv_n = 1'b0;
        tick(2);
        cv_n = 1'b1;
        tick(6);
        chk_bit(busy_n, 1'b1);
        cs_n = 1'b1;
        pd_n = 1'b1;
        tick(12);
        chk_bit(pwr, 1'b1);
        conv(12'h5a3, 1'b0, 1'b0, 37);
        rd(12'h5a3);
        $display("test shutdown done");
        // Two results fill the buffer; the third waits in store until a read.
        conv(12'h123, 1'b0, 1'b0, 37);
        conv(12'h456, 1'b1, 1'b0, 37);
        chk_bit(vld, 1'b1);
        fork
            conv(12'h789, 1'b1, 1'b0, 0);
            begin
                tick(60);
                chk_bit(busy_n, 1'b0);
                rd(12'h123);
            end
        join
        rd(12'hc56);
        rd(12'hf89);
        chk_bit(vld, 1'b0);
        $display("test buffer done");
        // A clock-enable gap of five cycles freezes a conversion, which ends late and intact.
        fork
            conv(12'h3c9, 1'b0, 1'b0, 42);
            begin
                tick(20);
                ce = 1'b0;
                tick(5);
                ce = 1'b1;
            end
        join
        rd(12'h3c9);
        $display("test enable done");
        close_out();
    end
endmodule : sar_adc_conversion_control_tb
